// >>> core/tsc_top.sv
// Purpose: Run, one-shot, capture/reload and polarity control of a 16-bit timer
// Assumes: 20 MHz clk, async active-high rst, primary pin is asynchronous
// Notes:   Counter counts every clk while running and ungated in timer mode; compare value is the capture register
//
// Overview of operation
// R01: Software uses the one-shot only in timer mode, never with counter select.
// R02: Compare one-shot emits one waveform period, reload to overflow, on pins.
// R03: Gated compare one-shot waits for ungated level; starts at once if present.
// R04: Gated one-shot output is unsupported in dual 8-bit mode.
// R05: Capture one-shot halts timer until selected edge or gating removed.
// R06: Running capture cycle keeps counting, gated, ends at next one-shot edge.
// R07: One-shot with run delays counting; one-shot alone overrides stopped run once.
// R08: Both edges selected: polarity 1 picks falling, 0 picks rising one-shot edge.
// R09: No flag is set on the starting edge of a one-shot capture.
// R10: Capture-reload enable 0 captures only; 1 captures and reloads on edges.
// R11: Both edges, reload, gate enable: skip reload on edge chosen by polarity.
// R12: Run control starts or stops the counter; high byte only in dual mode.
// R13: With run control 0 the count registers hold their value; the code still counts the low byte in dual mode and counts during a one-shot.
// R14: Low-half run control acts only in dual mode.
// R15: Enabled primary output starts at the level the polarity bit gives; the code sets this start level only in compare mode.
// R16: Polarity reaches the pin only when primary output enable rises.
// R17: Primary pin as input, not both edges: polarity picks the gating level.
// R18: Gate enable gates 16-bit or high byte, needs output off, timer mode.
// R19: Output enable field routes waveforms to primary and secondary pins.
// R20: Interrupt enable gates overflow and capture/compare flags onto the request.
// R21: Timer mode counts each enabled clock; overflow reloads and sets overflow flag.
//
// Design decisions made here: the register offsets and the plain strobed port.
`include "tsc_defines.svh"
`default_nettype none

module tsc_top #(
   parameter int HALF_W = `TSC_HALF_W
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire tsc_pkg::tsc_bus_s  bus,
   output var  logic [7:0]         rdata,
   input  wire logic               primary_timer_pin_in,
   input  wire logic               port_latch_primary,
   input  wire logic               port_oe_primary,
   input  wire logic               port_latch_secondary,
   input  wire logic               port_oe_secondary,
   output var  tsc_pkg::tsc_pins_s pins,
   output var  logic               timer_irq
);

   // Registers are byte wide; other halves cannot be served
   if (HALF_W != `TSC_HALF_W) begin : g_bad_width
      $error("tsc_top: HALF_W must be 8");
   end

   tsc_pkg::tsc_state_s q;
   tsc_pkg::tsc_state_s n;

   // Control field decode
   logic       gate_en;
   logic       one_shot_ctl;
   logic       capture_reload_en;
   logic       run_ctl;
   logic       low_half_run_ctl;
   logic       primary_polarity_sel;
   logic       primary_output_en;
   logic       timer_irq_en;
   logic       secondary_output_en;
   logic       counter_timer_select;
   logic       dual_byte_mode;
   logic       cap_mode;
   logic [1:0] edge_select_field;

   assign gate_en              = q.ctl_a[`TSC_A_GATE_EN];
   assign one_shot_ctl         = q.ctl_a[`TSC_A_ONE_SHOT];
   assign capture_reload_en    = q.ctl_a[`TSC_A_CAP_RLD_EN];
   assign run_ctl              = q.ctl_a[`TSC_A_RUN];
   assign low_half_run_ctl     = q.ctl_a[`TSC_A_LOW_RUN];
   assign primary_polarity_sel = q.ctl_a[`TSC_A_POLARITY];
   assign primary_output_en    = q.ctl_a[`TSC_A_PRI_OE];
   assign timer_irq_en         = q.ctl_a[`TSC_A_IRQ_EN];
   assign secondary_output_en  = q.ctl_b[`TSC_B_SEC_OE];
   assign counter_timer_select = q.ctl_b[`TSC_B_CNT_SEL];
   assign dual_byte_mode       = q.ctl_b[`TSC_B_DUAL];
   assign cap_mode             = q.ctl_b[`TSC_B_CAP_MODE];
   assign edge_select_field    = q.ctl_b[`TSC_B_ESEL_HI:`TSC_B_ESEL_LO];

   // Pin edges, taken only from the second and third sync stages
   logic pin_lvl;
   logic pin_rise;
   logic pin_fall;
   logic sel_edge;
   logic os_edge;

   assign pin_lvl  = q.pin_s2;
   assign pin_rise = q.pin_s2 & ~q.pin_s3;
   assign pin_fall = ~q.pin_s2 & q.pin_s3;

   // Edges picked by the edge select field
   always_comb
   begin
      case (edge_select_field)
         `TSC_EDGE_RISE: sel_edge = pin_rise;
         `TSC_EDGE_FALL: sel_edge = pin_fall;
         `TSC_EDGE_BOTH: sel_edge = pin_rise | pin_fall;
         default:        sel_edge = 1'b0;
      endcase
   end

   // R08: both-edge one-shot edge
   assign os_edge = (edge_select_field == `TSC_EDGE_BOTH) ?
                    (primary_polarity_sel ? pin_fall : pin_rise) : sel_edge;

   // Gating and count enables
   logic timer_mode;
   logic tick;
   logic gate_active;
   logic gate_open;
   logic os_start;
   logic hi_run;
   logic hi_en;
   logic lo_en;
   logic cap_ev;
   logic skip_rld;

   assign timer_mode = ~counter_timer_select;
   // Counter mode counts primary pin rising edges instead of clocks
   assign tick = timer_mode | pin_rise;

   // R18: gating only with output off, timer mode
   assign gate_active = gate_en & ~primary_output_en & timer_mode &
                        (edge_select_field != `TSC_EDGE_BOTH);
   // R17: pin level equal to polarity holds the clock
   assign gate_open = ~gate_active | (pin_lvl != primary_polarity_sel);

   // R03: compare one-shot waits for the ungated level
   // R04: dual mode ignores gating for the one-shot start
   // R05: capture one-shot starts on edge or gate release
   assign os_start = cap_mode ? (os_edge | (gate_active & gate_open))
                              : (gate_open | dual_byte_mode);

   // R07: one-shot overrides or delays the run control
   // R12: run control drives the full count or the high byte
   // R13: count held while not running
   always_comb
   begin
      case (q.os)
         // A fresh one-shot write must not leak a tick before the sequencer waits
         tsc_pkg::TSC_OS_IDLE: hi_run = run_ctl & ~(one_shot_ctl & timer_mode);
         tsc_pkg::TSC_OS_WAIT: hi_run = 1'b0;
         tsc_pkg::TSC_OS_RUN:  hi_run = 1'b1;
         default:              hi_run = 1'b0;
      endcase
   end

   // R06: running one-shot still obeys the gate
   assign hi_en = hi_run & gate_open & tick;
   // R14: low run control only in dual mode
   assign lo_en = dual_byte_mode ? (low_half_run_ctl & tick) : hi_en;

   // R10: capture event; the one-shot starting edge never captures
   assign cap_ev = cap_mode & timer_mode & sel_edge & (q.os != tsc_pkg::TSC_OS_WAIT);
   // R11: reload skipped on the edge named by polarity
   assign skip_rld = (edge_select_field == `TSC_EDGE_BOTH) & gate_en &
                     (primary_polarity_sel ? pin_rise : pin_fall);

   // Counter arithmetic, shared by both modes
   logic       hi_wrap;
   logic       lo_wrap;
   logic       full_wrap;
   logic       cmp_hi;
   logic       cmp_lo;
   logic       cmp_full;
   logic [7:0] lo_inc;
   logic [7:0] hi_inc;

   assign lo_wrap   = (q.cnt_lo == `TSC_BYTE_MAX);
   assign hi_wrap   = (q.cnt_hi == `TSC_BYTE_MAX);
   assign full_wrap = hi_wrap & lo_wrap;
   assign lo_inc    = q.cnt_lo + `TSC_BYTE_ONE;
   assign hi_inc    = q.cnt_hi + `TSC_BYTE_ONE;
   assign cmp_hi    = (q.cnt_hi == q.cap_hi);
   assign cmp_lo    = (q.cnt_lo == q.cap_lo);
   assign cmp_full  = cmp_hi & cmp_lo;

   // Next state of the whole block
   logic ovf_set;
   logic ccf_set;
   logic hi_ovf;
   logic lo_ovf;
   logic oe0_rise;
   logic oe1_rise;

   always_comb
   begin
      n        = q;
      ovf_set  = 1'b0;
      ccf_set  = 1'b0;
      hi_ovf   = 1'b0;
      lo_ovf   = 1'b0;
      oe0_rise = primary_output_en & ~q.oe0_d;
      oe1_rise = secondary_output_en & ~q.oe1_d;

      // Two-stage synchroniser plus history stage
      n.pin_s1 = primary_timer_pin_in;
      n.pin_s2 = q.pin_s1;
      n.pin_s3 = q.pin_s2;
      n.oe0_d  = primary_output_en;
      n.oe1_d  = secondary_output_en;

      // R21: counting and overflow reload
      if (dual_byte_mode)
      begin
         if (hi_en)
         begin
            hi_ovf   = hi_wrap;
            n.cnt_hi = hi_wrap ? q.rld_hi : hi_inc;
         end
         if (lo_en)
         begin
            lo_ovf   = lo_wrap;
            n.cnt_lo = lo_wrap ? q.rld_lo : lo_inc;
         end
      end
      else if (hi_en)
      begin
         hi_ovf   = full_wrap;
         lo_ovf   = full_wrap;
         n.cnt_lo = full_wrap ? q.rld_lo : lo_inc;
         n.cnt_hi = full_wrap ? q.rld_hi : (lo_wrap ? hi_inc : q.cnt_hi);
      end
      ovf_set = hi_ovf | lo_ovf;

      // R10: capture, and reload when enabled
      if (cap_ev)
      begin
         n.cap_lo = q.cnt_lo;
         n.cap_hi = q.cnt_hi;
         ccf_set  = 1'b1;
         // R11: reload skipped on one edge
         if (capture_reload_en & ~skip_rld)
         begin
            n.cnt_lo = q.rld_lo;
            n.cnt_hi = q.rld_hi;
         end
      end

      // R16: polarity reaches the pin only on enable rise
      if (oe0_rise)
         n.pol_applied = primary_polarity_sel;

      // R02: compare waveform, start level at reload, toggle at match
      // R15: start level follows polarity
      if (!cap_mode)
      begin
         if (oe0_rise)
            n.wave_pri = primary_polarity_sel;
         else if (hi_ovf)
            n.wave_pri = q.pol_applied;
         else if (hi_en & (dual_byte_mode ? cmp_hi : cmp_full))
         begin
            n.wave_pri = ~q.pol_applied;
            ccf_set    = 1'b1;
         end
         if (oe1_rise)
            n.wave_sec = q.pol_applied;
         else if (dual_byte_mode ? lo_ovf : hi_ovf)
            n.wave_sec = q.pol_applied;
         else if (lo_en & (dual_byte_mode ? cmp_lo : cmp_full))
            n.wave_sec = ~q.pol_applied;
      end

      // One-shot sequencer
      case (q.os)
         tsc_pkg::TSC_OS_IDLE:
         begin
            // R01: counter mode leaves the one-shot bit inert
            if (one_shot_ctl & timer_mode)
               n.os = tsc_pkg::TSC_OS_WAIT;
         end
         tsc_pkg::TSC_OS_WAIT:
         begin
            // R09: starting edge sets no flag
            if (!one_shot_ctl | !timer_mode)
               n.os = tsc_pkg::TSC_OS_IDLE;
            else if (os_start)
               n.os = tsc_pkg::TSC_OS_RUN;
         end
         tsc_pkg::TSC_OS_RUN:
         begin
            // R06: capture cycle ends at the one-shot edge
            if (!one_shot_ctl | !timer_mode)
               n.os = tsc_pkg::TSC_OS_IDLE;
            else if (cap_mode ? os_edge : hi_ovf)
            begin
               n.os                     = tsc_pkg::TSC_OS_IDLE;
               n.ctl_a[`TSC_A_ONE_SHOT] = 1'b0;
            end
         end
         default:
            n.os = tsc_pkg::TSC_OS_IDLE;
      endcase

      // Flags: write one clears, a set in the same cycle wins
      n.ovf = q.ovf | ovf_set;
      n.ccf = q.ccf | ccf_set;
      if (bus.wr & (bus.addr == `TSC_OFF_STATUS))
      begin
         n.ovf = (q.ovf & ~bus.wdata[`TSC_S_OVF]) | ovf_set;
         n.ccf = (q.ccf & ~bus.wdata[`TSC_S_CCF]) | ccf_set;
      end

      // Software writes override hardware updates of the same byte
      if (bus.wr)
      begin
         case (bus.addr)
            `TSC_OFF_CTL_A:  n.ctl_a  = bus.wdata;
            `TSC_OFF_CTL_B:  n.ctl_b  = bus.wdata;
            `TSC_OFF_CNT_LO: n.cnt_lo = bus.wdata;
            `TSC_OFF_CNT_HI: n.cnt_hi = bus.wdata;
            `TSC_OFF_RLD_LO: n.rld_lo = bus.wdata;
            `TSC_OFF_RLD_HI: n.rld_hi = bus.wdata;
            `TSC_OFF_CAP_LO: n.cap_lo = bus.wdata;
            `TSC_OFF_CAP_HI: n.cap_hi = bus.wdata;
            default:         n.ctl_a  = n.ctl_a;
         endcase
      end

      // Read data valid the cycle after the strobe, zero otherwise
      n.rdata = `TSC_RST_BYTE;
      if (bus.rd)
      begin
         case (bus.addr)
            `TSC_OFF_CTL_A:  n.rdata = q.ctl_a;
            `TSC_OFF_CTL_B:  n.rdata = q.ctl_b;
            `TSC_OFF_CNT_LO: n.rdata = q.cnt_lo;
            `TSC_OFF_CNT_HI: n.rdata = q.cnt_hi;
            `TSC_OFF_RLD_LO: n.rdata = q.rld_lo;
            `TSC_OFF_RLD_HI: n.rdata = q.rld_hi;
            `TSC_OFF_CAP_LO: n.rdata = q.cap_lo;
            `TSC_OFF_CAP_HI: n.rdata = q.cap_hi;
            `TSC_OFF_STATUS:
            begin
               n.rdata[`TSC_S_OVF]     = q.ovf;
               n.rdata[`TSC_S_CCF]     = q.ccf;
               n.rdata[`TSC_S_OS_BUSY] = (q.os != tsc_pkg::TSC_OS_IDLE);
            end
            default:         n.rdata = `TSC_RST_BYTE;
         endcase
      end

      // R19: output enable field routes waveforms, else port latch data
      n.pins.pri_out = primary_output_en ? n.wave_pri : port_latch_primary;
      n.pins.pri_oe  = primary_output_en | port_oe_primary;
      n.pins.sec_out = secondary_output_en ? n.wave_sec : port_latch_secondary;
      n.pins.sec_oe  = secondary_output_en | port_oe_secondary;

      // R20: local enable for both timer flags
      n.irq = n.ctl_a[`TSC_A_IRQ_EN] & (n.ovf | n.ccf);
   end

   // State register; every field resets to a constant
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         q <= '0;
      else
         q <= n;
   end

   // Outputs straight from flip-flops
   assign rdata     = q.rdata;
   assign pins      = q.pins;
   assign timer_irq = q.irq;

endmodule : tsc_top

`default_nettype wire

// >>> include/tsc_defines.svh
// Purpose: Register offsets, field positions, reset values and codes for the timer control
// Assumes: 8-bit register port with a 4-bit address
// Notes:   Definitions only; included by the package and the core
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH

// Register offsets
`define TSC_ADDR_W        4
`define TSC_OFF_CTL_A     4'h0
`define TSC_OFF_CTL_B     4'h1
`define TSC_OFF_CNT_LO    4'h2
`define TSC_OFF_CNT_HI    4'h3
`define TSC_OFF_RLD_LO    4'h4
`define TSC_OFF_RLD_HI    4'h5
`define TSC_OFF_CAP_LO    4'h6
`define TSC_OFF_CAP_HI    4'h7
`define TSC_OFF_STATUS    4'h8

// Control A bit positions
`define TSC_A_GATE_EN     0
`define TSC_A_ONE_SHOT    1
`define TSC_A_CAP_RLD_EN  2
`define TSC_A_RUN         3
`define TSC_A_LOW_RUN     4
`define TSC_A_POLARITY    5
`define TSC_A_PRI_OE      6
`define TSC_A_IRQ_EN      7

// Control B bit positions
`define TSC_B_SEC_OE      0
`define TSC_B_CNT_SEL     1
`define TSC_B_DUAL        2
`define TSC_B_CAP_MODE    3
`define TSC_B_ESEL_HI     5
`define TSC_B_ESEL_LO     4

// Status bit positions
`define TSC_S_OVF         0
`define TSC_S_CCF         1
`define TSC_S_OS_BUSY     2

// Edge select codes, reset and limit values
`define TSC_EDGE_NONE     2'h0
`define TSC_EDGE_RISE     2'h1
`define TSC_EDGE_FALL     2'h2
`define TSC_EDGE_BOTH     2'h3
`define TSC_RST_BYTE      8'h00
`define TSC_BYTE_MAX      8'hFF
`define TSC_BYTE_ONE      8'h01
`define TSC_HALF_W        8

`endif

// >>> include/tsc_pkg.sv
// Purpose: Types shared by the timer control core and its bench
// Assumes: tsc_defines.svh supplies widths
// Notes:   The whole core state is one packed struct
`include "tsc_defines.svh"
`default_nettype none

package tsc_pkg;

   // One-shot sequencer states
   typedef enum logic [1:0] {TSC_OS_IDLE, TSC_OS_WAIT, TSC_OS_RUN} tsc_os_e;

   // Register port request
   typedef struct packed {
      logic [`TSC_ADDR_W-1:0] addr;
      logic [7:0]             wdata;
      logic                   wr;
      logic                   rd;
   } tsc_bus_s;

   // Timer pin drive
   typedef struct packed {
      logic pri_out;
      logic pri_oe;
      logic sec_out;
      logic sec_oe;
   } tsc_pins_s;

   // Complete core state
   typedef struct packed {
      logic [7:0] ctl_a;
      logic [7:0] ctl_b;
      logic [7:0] cnt_lo;
      logic [7:0] cnt_hi;
      logic [7:0] rld_lo;
      logic [7:0] rld_hi;
      logic [7:0] cap_lo;
      logic [7:0] cap_hi;
      logic       ovf;
      logic       ccf;
      tsc_os_e    os;
      logic       pin_s1;
      logic       pin_s2;
      logic       pin_s3;
      logic       oe0_d;
      logic       oe1_d;
      logic       pol_applied;
      logic       wave_pri;
      logic       wave_sec;
      logic [7:0] rdata;
      tsc_pins_s  pins;
      logic       irq;
   } tsc_state_s;

endpackage : tsc_pkg

`default_nettype wire

// >>> testbench/test_timer_single_shot_capture_ctl.sv
// Purpose: Self-checking bench for the timer control core
// Assumes: 50 ns clock, async active-high reset
// Notes:   Edge sync adds fixed latency, so measured counts use small windows
`default_nettype none

module test_timer_single_shot_capture_ctl;
   timeunit 1ns;
   timeprecision 1ns;

   logic               clk = 1'b0;
   logic               rst;
   tsc_pkg::tsc_bus_s  bus;
   logic [7:0]         rdata;
   logic               pin_level;
   logic               port_latch_primary;
   logic               port_oe_primary;
   logic               port_latch_secondary;
   logic               port_oe_secondary;
   tsc_pkg::tsc_pins_s pins;
   logic               timer_irq;
   logic               ext_en;
   logic               ext_level;
   logic [7:0]         v;
   logic [7:0]         w;
   int                 num_errors = 0;
   int                 checks = 0;
   int                 cycles = 0;

   tsc_top dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
      .primary_timer_pin_in(pin_level), .port_latch_primary(port_latch_primary),
      .port_oe_primary(port_oe_primary), .port_latch_secondary(port_latch_secondary),
      .port_oe_secondary(port_oe_secondary), .pins(pins), .timer_irq(timer_irq));

   tsc_pin_model far (.clk(clk), .ext_en(ext_en), .ext_level(ext_level), .pins(pins),
      .pin_level(pin_level));

   // Clock
   always #25 clk = ~clk;

   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         results();
      end
   end

   task results();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results

   task chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr

   // Data stand only in the cycle after the strobe
   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd

   task t_regs();
      rd(4'h0, v);
      chk(v, 8'h00, "ctl a reset");
      rd(4'h8, v);
      chk(v, 8'h00, "status reset");
      wr(4'hC, 8'h5A);
      rd(4'hC, v);
      chk(v, 8'h00, "unmapped");
      wr(4'h1, 8'h2C);
      rd(4'h1, v);
      chk(v, 8'h2C, "ctl b readback");
      wr(4'h1, 8'h00);
   endtask : t_regs

   task t_run();
      wr(4'h0, 8'h08);
      repeat (20) @(posedge clk);
      wr(4'h0, 8'h00);
      rd(4'h2, v);
      chk({7'h00, v >= 8'h14 && v <= 8'h18}, 8'h01, "run count");
      wr(4'h0, 8'h10);
      repeat (10) @(posedge clk);
      rd(4'h2, w);
      chk(w, v, "low run ignored");
      wr(4'h1, 8'h04);
      repeat (10) @(posedge clk);
      rd(4'h2, w);
      chk({7'h00, w != v}, 8'h01, "low half counts");
      rd(4'h3, w);
      chk(w, 8'h00, "high half held");
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h00);
   endtask : t_run

   task t_ovf();
      wr(4'h2, 8'hF0);
      wr(4'h3, 8'hFF);
      wr(4'h4, 8'h34);
      wr(4'h5, 8'h12);
      wr(4'h0, 8'h88);
      repeat (30) @(posedge clk);
      wr(4'h0, 8'h80);
      rd(4'h8, v);
      chk(v & 8'h01, 8'h01, "overflow flag");
      rd(4'h3, v);
      chk(v, 8'h12, "reloaded");
      chk({7'h00, timer_irq}, 8'h01, "irq on");
      wr(4'h8, 8'h03);
      @(posedge clk);
      #1;
      chk({7'h00, timer_irq}, 8'h00, "irq cleared");
      wr(4'h0, 8'h00);
   endtask : t_ovf

   task t_cap();
      ext_level <= 1'b0;
      wr(4'h2, 8'h00);
      wr(4'h3, 8'h00);
      wr(4'h1, 8'h18);
      wr(4'h0, 8'h0A);
      repeat (10) @(posedge clk);
      rd(4'h2, v);
      chk(v, 8'h00, "held before edge");
      @(posedge clk);
      ext_level <= 1'b1;
      repeat (6) @(posedge clk);
      rd(4'h8, v);
      chk(v & 8'h06, 8'h04, "no flag at start");
      repeat (22) @(posedge clk);
      ext_level <= 1'b0;
      repeat (10) @(posedge clk);
      ext_level <= 1'b1;
      repeat (6) @(posedge clk);
      rd(4'h8, v);
      chk(v & 8'h06, 8'h02, "cycle ended");
      rd(4'h6, v);
      chk({7'h00, v >= 8'h26 && v <= 8'h2A}, 8'h01, "period");
      rd(4'h2, v);
      rd(4'h2, w);
      chk({7'h00, w != v}, 8'h01, "run resumes");
      wr(4'h0, 8'h00);
      wr(4'h8, 8'h03);
   endtask : t_cap

   task t_both();
      wr(4'h2, 8'h00);
      wr(4'h1, 8'h38);
      wr(4'h0, 8'h27);
      repeat (10) @(posedge clk);
      ext_level <= 1'b0;
      repeat (20) @(posedge clk);
      ext_level <= 1'b1;
      repeat (6) @(posedge clk);
      rd(4'h8, v);
      chk(v & 8'h04, 8'h04, "rise not end");
      repeat (10) @(posedge clk);
      ext_level <= 1'b0;
      repeat (6) @(posedge clk);
      rd(4'h8, v);
      chk(v & 8'h04, 8'h00, "fall ends");
      rd(4'h2, v);
      repeat (5) @(posedge clk);
      rd(4'h2, w);
      chk(w, v, "one cycle only");
      chk(v, 8'h34, "reload on fall");
      rd(4'h7, w);
      chk(w, 8'h00, "no reload on rise");
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h00);
   endtask : t_both

   task t_wave();
      wr(4'h6, 8'h80);
      wr(4'h0, 8'h20);
      wr(4'h0, 8'h60);
      @(posedge clk);
      #1;
      chk({6'h00, pins.pri_oe, pins.pri_out}, 8'h03, "start high");
      wr(4'h0, 8'h40);
      @(posedge clk);
      #1;
      chk({7'h00, pins.pri_out}, 8'h01, "polarity deferred");
      wr(4'h0, 8'h00);
      wr(4'h0, 8'h40);
      @(posedge clk);
      #1;
      chk({7'h00, pins.pri_out}, 8'h00, "start low");
      wr(4'h0, 8'h00);
      port_latch_primary <= 1'b1;
      port_oe_primary <= 1'b1;
      {port_latch_secondary, port_oe_secondary} <= 2'h3;
      wr(4'h1, 8'h01);
      @(posedge clk);
      #1;
      chk({6'h00, pins.pri_oe, pins.pri_out, pins.sec_oe}, 8'h07, "routing");
      port_latch_primary <= 1'b0;
      port_oe_primary <= 1'b0;
      {port_latch_secondary, port_oe_secondary} <= 2'h0;
      wr(4'h1, 8'h00);
      // Pin low matches polarity 0, so the clock is held
      ext_level <= 1'b0;
      wr(4'h0, 8'h09);
      rd(4'h2, v);
      repeat (5) @(posedge clk);
      rd(4'h2, w);
      chk(w, v, "gated hold");
      ext_level <= 1'b1;
      repeat (5) @(posedge clk);
      rd(4'h2, w);
      chk({7'h00, w != v}, 8'h01, "gate open");
      wr(4'h0, 8'h00);
   endtask : t_wave

   task t_shot();
      int n;
      logic prev;
      n = 0;
      prev = 1'b0;
      wr(4'h2, 8'hF0);
      wr(4'h3, 8'hFF);
      wr(4'h4, 8'hF0);
      wr(4'h5, 8'hFF);
      wr(4'h6, 8'hF8);
      wr(4'h7, 8'hFF);
      wr(4'h0, 8'h42);
      for (int i = 0; i < 60; i++)
      begin
         @(posedge clk);
         #1;
         if (pins.pri_out !== prev)
            n++;
         prev = pins.pri_out;
      end
      chk(n[7:0], 8'h02, "one period");
      rd(4'h0, v);
      chk(v & 8'h02, 8'h00, "one-shot done");
   endtask : t_shot

   // Main sequence
   initial
   begin
      rst = 1'b0;
      bus = '0;
      {port_latch_primary, port_oe_primary} = 2'h0;
      {port_latch_secondary, port_oe_secondary} = 2'h0;
      ext_en = 1'b1;
      ext_level = 1'b0;
      #5 rst = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_run();
      t_ovf();
      t_cap();
      t_both();
      t_wave();
      t_shot();
      results();
   end
endmodule : test_timer_single_shot_capture_ctl

bind tsc_top tsc_top_asserts u_chk (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
   .port_latch_primary(port_latch_primary), .port_oe_primary(port_oe_primary),
   .port_latch_secondary(port_latch_secondary), .port_oe_secondary(port_oe_secondary),
   .pins(pins), .timer_irq(timer_irq));

`default_nettype wire

// >>> testbench/tsc_pin_model.sv
// Purpose: Far-side model of the primary timer pin
// Assumes: Bench picks the level it drives; the core may drive the pin itself
// Notes:   A released line wanders every cycle so no stale level fakes an edge
`default_nettype none

module tsc_pin_model (
   input  wire logic               clk,
   input  wire logic               ext_en,
   input  wire logic               ext_level,
   input  wire tsc_pkg::tsc_pins_s pins,
   output var  logic               pin_level
);
   timeunit 1ns;
   timeprecision 1ns;

   logic float_q = 1'b0;

   // Wander of an undriven line
   always_ff @(posedge clk)
      float_q <= ~float_q;

   // Core drive wins, then the outside source
   always_comb
      pin_level = pins.pri_oe ? pins.pri_out : (ext_en ? ext_level : float_q);
endmodule : tsc_pin_model

`default_nettype wire

// >>> testbench/tsc_top_asserts.sv
// Purpose: Port-level checks of the timer control core
// Assumes: Control A at offset 0, control B at offset 1
// Notes:   Shadows track software bits only; hardware-cleared one-shot may read stale
`default_nettype none

module tsc_top_asserts (
   input wire logic               clk,
   input wire logic               rst,
   input wire tsc_pkg::tsc_bus_s  bus,
   input wire logic [7:0]         rdata,
   input wire logic               port_latch_primary,
   input wire logic               port_oe_primary,
   input wire logic               port_latch_secondary,
   input wire logic               port_oe_secondary,
   input wire tsc_pkg::tsc_pins_s pins,
   input wire logic               timer_irq
);
   logic [7:0] sh_a;
   logic [7:0] sh_b;
   wire  logic ctl_idle = (sh_a[4:1] == 4'h0);

   // Shadow of control writes; stale one-shot only makes checks more cautious
   always_ff @(posedge clk or posedge rst)
      if (rst)
         {sh_a, sh_b} <= 16'h0000;
      else if (bus.wr && bus.addr == 4'h0)
         sh_a <= bus.wdata;
      else if (bus.wr && bus.addr == 4'h1)
         sh_b <= bus.wdata;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   pri_port_a:
      assert property (!sh_a[6] |=> {pins.pri_out, pins.pri_oe} ==
         {$past(port_latch_primary), $past(port_oe_primary)})
      else $error("primary pin not on port data");
   pri_drive_a:
      assert property (sh_a[6] |=> pins.pri_oe)
      else $error("primary pin not driven");
   sec_port_a:
      assert property (!sh_b[0] |=> {pins.sec_out, pins.sec_oe} ==
         {$past(port_latch_secondary), $past(port_oe_secondary)})
      else $error("secondary pin not on port data");
   sec_drive_a:
      assert property (sh_b[0] |=> pins.sec_oe)
      else $error("secondary pin not driven");
   start_level_a:
      assert property ($rose(sh_a[6]) && ctl_idle |=> pins.pri_out == $past(sh_a[5]))
      else $error("wrong start level");
   pol_hold_a:
      assert property (sh_a[6] && $past(sh_a[6]) && ctl_idle && $past(ctl_idle)
         |=> $stable(pins.pri_out))
      else $error("polarity reached pin early");
   irq_gate_a:
      assert property (!sh_a[7] && !(bus.wr && bus.addr == 4'h0 && bus.wdata[7]) |=> !timer_irq)
      else $error("request while disabled");
   rdata_idle_a:
      assert property (!bus.rd |=> rdata == 8'h00)
      else $error("read data without read");
   unmapped_read_a:
      assert property (bus.rd && bus.addr > 4'h8 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   reset_quiet_a:
      assert property (disable iff (1'b0) rst |-> pins == 4'h0 && !timer_irq)
      else $error("outputs active in reset");

   os_write_c: cover property (bus.wr && bus.addr == 4'h0 && bus.wdata[1]);
   oe_rise_c: cover property ($rose(pins.pri_oe));
   irq_c: cover property (timer_irq);
endmodule : tsc_top_asserts

`default_nettype wire
